/* design/thermal_status_pkg.sv */
// Purpose: shared constants for the thermal status flag logic
// Assumes: 40 MHz core clock, five channels (local plus remotes 1 to 4)
// Notes: command bytes select the status registers on the read link
//
// Functional notes
// - busy bit high while converting
// - not-ready bit set for 30 ms power-up
// - reserved status bits always read zero
// - summary bits are OR of detailed registers
// - fault register: open odd, short even bits
// - short: pin low; open: pin high/floating
// - faulted reading forced to 0 / -128
// - alarm bits: remotes 4..1 then local
// - alarm bit sets when reading reaches limit
// - alarm bit clears below limit minus hysteresis
// - any unmasked alarm bit drives output low
// - output released when all bits clear
// - mask one blocks channel, zero passes
// - third/fourth registers feed outputs b, c
package thermal_status_pkg;
    // -------------------------------------------------------------
    // command bytes
    // -------------------------------------------------------------
    localparam logic [7:0] CMD_COMMON_STATUS = 8'h02;
    localparam logic [7:0] CMD_DIODE_FAULT = 8'h07;
    localparam logic [7:0] CMD_ALARM_A = 8'h08;
    localparam logic [7:0] CMD_ALARM_B = 8'h09;
    localparam logic [7:0] CMD_ALARM_C = 8'h0A;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    // -------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------
    localparam int BIT_BUSY = 7;
    localparam int BIT_INIT = 6;
    localparam logic [7:0] COMMON_STATUS_RESET = 8'h00;
    localparam logic [7:0] DIODE_FAULT_RESET = 8'h00;
    localparam logic [4:0] ALARM_RESET = 5'h00;
    localparam int NUM_CH = 5;
    localparam int NUM_REMOTE = 4;
    // -------------------------------------------------------------
    // forced readings while a diode is faulted
    // -------------------------------------------------------------
    localparam logic [7:0] FAULT_TEMP_U = 8'h00;
    localparam logic [7:0] FAULT_TEMP_S = 8'h80;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int INIT_TIME_MS = 30;
    localparam int INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);
    localparam int INIT_CNT_W = 21;
    // -------------------------------------------------------------
    // link side read handshake states
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b01,
        LINK_WAIT = 2'b10
    } link_state_t;
endpackage

/* design/bit_sync.sv */
// Purpose: two flip-flop synchroniser for one level
// Assumes: input is asynchronous to clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
    // clock
    input wire logic clk,
    // level in and out
    input wire logic async_in,
    output logic sync_out
);
    logic meta; // first stage, metastability catcher

    // ----------------------------------------------------------------
    // two stages, no reset so no reset path crosses domains
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        meta <= async_in;
        sync_out <= meta;
    end
endmodule // bit_sync
`default_nettype wire

/* design/alarm_hyst_cell.sv */
// Purpose: one channel alarm flag with shared hysteresis
// Assumes: reading and limit are signed degrees, hysteresis unsigned
// Notes: evaluated only on the end of that channel's conversion
`timescale 1ns/1ps
`default_nettype none
module alarm_hyst_cell (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // evaluation inputs
    input wire logic eval,
    input wire logic signed [7:0] reading,
    input wire logic signed [7:0] limit,
    input wire logic [7:0] hyst,
    // flag
    output logic flag
);
    logic next_flag; // next flag value
    logic signed [9:0] r_ext; // widened reading
    logic signed [9:0] l_ext; // widened limit
    logic signed [9:0] low_ext; // clear threshold, never wraps

    assign r_ext = 10'(reading);
    assign l_ext = 10'(limit);
    assign low_ext = l_ext - $signed({2'b00, hyst});

    // ----------------------------------------------------------------
    // set at limit, clear below limit minus hysteresis, else hold
    // ----------------------------------------------------------------
    always_comb
    begin
        next_flag = flag;
        if (eval)
        begin
            if (r_ext >= l_ext)
                next_flag = 1'b1;
            else if (r_ext < low_ext)
                next_flag = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            flag <= 1'b0;
        else
            flag <= next_flag;
    end

    property p_set_at_limit;
        @(posedge clk) disable iff (reset) (eval && r_ext >= l_ext) |=> flag;
    endproperty
    a_set_at_limit: assert property (p_set_at_limit)
        else $error("alarm flag did not set at limit");
    property p_clear_below;
        @(posedge clk) disable iff (reset) (eval && r_ext < low_ext) |=> !flag;
    endproperty
    a_clear_below: assert property (p_clear_below)
        else $error("alarm flag did not clear below band");
    property p_band_hold;
        @(posedge clk) disable iff (reset)
            (eval && r_ext < l_ext && r_ext >= low_ext) |=> (flag == $past(flag));
    endproperty
    a_band_hold: assert property (p_band_hold)
        else $error("alarm flag changed inside hysteresis band");
endmodule // alarm_hyst_cell
`default_nettype wire

/* design/thermal_status_flag_logic.sv */
// Purpose: status flags, alarm outputs and status read port
// Assumes: sequencer runs on clk; front-end fault comparators are async
// Notes: reads arrive on link_clk and cross by a toggle handshake
`timescale 1ns/1ps
`default_nettype none
module thermal_status_flag_logic
    import thermal_status_pkg::*;
#(
    parameter int INIT_LEN = thermal_status_pkg::INIT_CYCLES
) (
    // core clock and reset
    input wire logic clk,
    input wire logic reset,
    // conversion sequencer
    input wire logic conv_active,
    input wire logic conv_done,
    input wire logic [2:0] conv_chan,
    input wire logic [7:0] conv_temp_u,
    input wire logic [7:0] conv_temp_s,
    // diode front end, remotes 4..1 in bits 3..0
    input wire logic [3:0] diode_low_pin,
    input wire logic [3:0] diode_high_pin,
    // limits, hysteresis and masks
    input wire logic [4:0][7:0] limit_a,
    input wire logic [1:0][7:0] limit_b12,
    input wire logic [7:0] hysteresis,
    input wire logic [4:0] mask_a,
    input wire logic [4:0] mask_b,
    input wire logic [4:0] mask_c,
    // forced readings
    output logic [7:0] temp_u_out,
    output logic [7:0] temp_s_out,
    // alarm outputs, low active
    output logic alarm_out_a_n,
    output logic alarm_out_b_n,
    output logic alarm_out_c_n,
    // status read link
    input wire logic link_clk,
    input wire logic rd_req,
    input wire logic [7:0] rd_cmd,
    output logic rd_ready,
    output logic rd_valid,
    output logic [7:0] rd_data
);
    import thermal_status_pkg::*;

    localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(INIT_LEN - 1);

    // ----------------------------------------------------------------
    // power-up and busy state
    // ----------------------------------------------------------------
    logic init_pending_flag, next_init_pending; // not-ready bit
    logic [INIT_CNT_W-1:0] init_count, next_init_count; // power-up timer
    logic busy_flag, next_busy; // converting bit

    // sequencer is the cause; register it so the bit is a clean flop
    always_comb
    begin
        next_busy = conv_active;
        next_init_count = init_count;
        next_init_pending = init_pending_flag;
        if (init_pending_flag)
        begin
            if (init_count == INIT_LAST)
                next_init_pending = 1'b0;
            else
                next_init_count = init_count + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            busy_flag <= 1'b0;
            init_pending_flag <= 1'b1;
            init_count <= '0;
        end
        else
        begin
            busy_flag <= next_busy;
            init_pending_flag <= next_init_pending;
            init_count <= next_init_count;
        end
    end

    // ----------------------------------------------------------------
    // diode fault sensing and forced readings
    // ----------------------------------------------------------------
    logic [3:0] low_s; // D+ at ground or D-
    logic [3:0] high_s; // D+ at supply or floating
    logic [7:0] diode_fault_status, next_fault; // fault register
    logic [7:0] next_temp_u, next_temp_s;
    logic remote_hit; // conversion ended on a remote channel
    logic [1:0] rsel; // remote index 0..3
    logic ch_fault; // the converted remote is faulted now
    logic signed [7:0] eff_temp_s; // reading used for compares

    genvar g;
    generate
        for (g = 0; g < NUM_REMOTE; g++)
        begin : g_pin_sync
            bit_sync u_low (.clk(clk), .async_in(diode_low_pin[g]), .sync_out(low_s[g]));
            bit_sync u_high (.clk(clk), .async_in(diode_high_pin[g]), .sync_out(high_s[g]));
        end
    endgenerate

    assign remote_hit = conv_done && (conv_chan != 3'h0) && (conv_chan <= 3'h4);
    assign rsel = 2'(conv_chan - 3'h1);
    assign ch_fault = remote_hit && (low_s[rsel] || high_s[rsel]);
    assign eff_temp_s = ch_fault ? FAULT_TEMP_S : conv_temp_s;

    // faults latch at each conversion end of that remote
    always_comb
    begin
        next_fault = diode_fault_status;
        next_temp_u = temp_u_out;
        next_temp_s = temp_s_out;
        if (remote_hit)
        begin
            next_fault[{rsel, 1'b1}] = high_s[rsel];
            next_fault[{rsel, 1'b0}] = low_s[rsel];
        end
        if (conv_done)
        begin
            next_temp_u = ch_fault ? FAULT_TEMP_U : conv_temp_u;
            next_temp_s = eff_temp_s;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            diode_fault_status <= DIODE_FAULT_RESET;
            temp_u_out <= FAULT_TEMP_U;
            temp_s_out <= FAULT_TEMP_U;
        end
        else
        begin
            diode_fault_status <= next_fault;
            temp_u_out <= next_temp_u;
            temp_s_out <= next_temp_s;
        end
    end

    // ----------------------------------------------------------------
    // alarm flags: set a against limit_a, set b uses second limits on
    // remotes 1 and 2; set c compares the same limits as set b
    // ----------------------------------------------------------------
    logic [4:0] flags_a; // bit 0 local, bits 4..1 remotes
    logic [4:0] flags_b;

    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_cells
            logic ev;
            assign ev = conv_done && (conv_chan == 3'(g));
            alarm_hyst_cell u_a (.clk(clk), .reset(reset), .eval(ev),
                .reading(eff_temp_s), .limit(limit_a[g]), .hyst(hysteresis),
                .flag(flags_a[g]));
            alarm_hyst_cell u_b (.clk(clk), .reset(reset), .eval(ev),
                .reading(eff_temp_s),
                .limit((g == 1 || g == 2) ? limit_b12[g == 2] : limit_a[g]),
                .hyst(hysteresis), .flag(flags_b[g]));
        end
    endgenerate

    // ----------------------------------------------------------------
    // alarm outputs, one flop each, low while any unmasked bit is set
    // ----------------------------------------------------------------
    logic next_out_a, next_out_b, next_out_c;

    always_comb
    begin
        next_out_a = ~|(flags_a & ~mask_a);
        next_out_b = ~|(flags_b & ~mask_b);
        next_out_c = ~|(flags_b & ~mask_c);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            alarm_out_a_n <= 1'b1;
            alarm_out_b_n <= 1'b1;
            alarm_out_c_n <= 1'b1;
        end
        else
        begin
            alarm_out_a_n <= next_out_a;
            alarm_out_b_n <= next_out_b;
            alarm_out_c_n <= next_out_c;
        end
    end

    // ----------------------------------------------------------------
    // register view and command decode
    // ----------------------------------------------------------------
    logic [7:0] common_status;
    logic status_one_any_flag, status_two_any_flag;
    logic status_three_any_flag, status_four_any_flag;

    assign status_one_any_flag = |diode_fault_status;
    assign status_two_any_flag = |flags_a;
    assign status_three_any_flag = |flags_b;
    assign status_four_any_flag = |flags_b;
    assign common_status = {busy_flag, init_pending_flag, 2'b00,
        status_four_any_flag, status_three_any_flag,
        status_two_any_flag, status_one_any_flag};

    // unknown commands answer zero rather than stalling the host
    function automatic logic [7:0] decode_read(input logic [7:0] cmd);
        logic [7:0] d;
        d = UNMAPPED_DATA;
        unique case (cmd)
            CMD_COMMON_STATUS: d = common_status;
            CMD_DIODE_FAULT: d = diode_fault_status;
            CMD_ALARM_A: d = {3'b000, flags_a};
            CMD_ALARM_B, CMD_ALARM_C: d = {3'b000, flags_b};
            default: d = UNMAPPED_DATA;
        endcase
        return d;
    endfunction

    // ----------------------------------------------------------------
    // core side of the read handshake
    // ----------------------------------------------------------------
    logic req_tog; // link domain request toggle
    logic [7:0] link_cmd; // held stable while a request is open
    logic req_s, req_d, ack_tog, next_ack_tog;
    logic [7:0] snap_data, next_snap; // stable until next request
    logic ans_fire;

    bit_sync u_req_sync (.clk(clk), .async_in(req_tog), .sync_out(req_s));
    assign ans_fire = req_s ^ req_d;

    always_comb
    begin
        next_ack_tog = ack_tog;
        next_snap = snap_data;
        if (ans_fire)
        begin
            next_snap = decode_read(link_cmd);
            next_ack_tog = ~ack_tog;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            req_d <= 1'b0;
            ack_tog <= 1'b0;
            snap_data <= COMMON_STATUS_RESET;
        end
        else
        begin
            req_d <= req_s;
            ack_tog <= next_ack_tog;
            snap_data <= next_snap;
        end
    end

    // ----------------------------------------------------------------
    // link side: one read in flight at a time
    // ----------------------------------------------------------------
    logic link_rst, ack_s, ack_d, ack_edge;
    link_state_t link_state, next_link_state;
    logic next_req_tog, next_rd_ready, next_rd_valid;
    logic [7:0] next_link_cmd, next_rd_data;

    bit_sync u_rst_sync (.clk(link_clk), .async_in(reset), .sync_out(link_rst));
    bit_sync u_ack_sync (.clk(link_clk), .async_in(ack_tog), .sync_out(ack_s));
    assign ack_edge = ack_s ^ ack_d;

    always_comb
    begin
        next_link_state = link_state;
        next_req_tog = req_tog;
        next_link_cmd = link_cmd;
        next_rd_data = rd_data;
        next_rd_valid = 1'b0;
        unique case (link_state)
            LINK_IDLE:
                if (rd_req && rd_ready)
                begin
                    next_req_tog = ~req_tog;
                    next_link_cmd = rd_cmd;
                    next_link_state = LINK_WAIT;
                end
            LINK_WAIT:
                if (ack_edge)
                begin
                    next_rd_data = snap_data;
                    next_rd_valid = 1'b1;
                    next_link_state = LINK_IDLE;
                end
            default: next_link_state = LINK_IDLE;
        endcase
        next_rd_ready = (next_link_state == LINK_IDLE);
    end

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            link_state <= LINK_IDLE;
            req_tog <= 1'b0;
            link_cmd <= CMD_COMMON_STATUS;
            ack_d <= 1'b0;
            rd_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= UNMAPPED_DATA;
        end
        else
        begin
            link_state <= next_link_state;
            req_tog <= next_req_tog;
            link_cmd <= next_link_cmd;
            ack_d <= ack_s;
            rd_ready <= next_rd_ready;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_busy_follows;
        @(posedge clk) disable iff (reset) conv_active ##1 conv_active |=> busy_flag[*1];
    endproperty
    a_busy_follows: assert property (p_busy_follows)
        else $error("busy bit low during conversion");
    property p_init_done;
        @(posedge clk) disable iff (reset)
            (init_pending_flag && init_count == INIT_LAST) |=> !init_pending_flag [*2];
    endproperty
    a_init_done: assert property (p_init_done)
        else $error("not-ready bit stayed after power-up time");
    property p_reserved_zero;
        @(posedge clk) disable iff (reset)
            (ans_fire && link_cmd == CMD_COMMON_STATUS) |=> (snap_data[5:4] == 2'b00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved common status bits not zero");
    property p_summary_two;
        @(posedge clk) disable iff (reset)
            (ans_fire && link_cmd == CMD_COMMON_STATUS) |=> (snap_data[1] == |$past(flags_a));
    endproperty
    a_summary_two: assert property (p_summary_two)
        else $error("summary bit disagrees with alarm register");
    property p_open_r4;
        @(posedge clk) disable iff (reset)
            (conv_done && conv_chan == 3'h4 && high_s[3]) |=> diode_fault_status[7];
    endproperty
    a_open_r4: assert property (p_open_r4)
        else $error("remote 4 open fault not at bit 7");
    property p_forced_reading;
        @(posedge clk) disable iff (reset)
            ch_fault |=> (temp_u_out == FAULT_TEMP_U && temp_s_out == FAULT_TEMP_S);
    endproperty
    a_forced_reading: assert property (p_forced_reading)
        else $error("faulted reading not forced");
    property p_alarm_on;
        @(posedge clk) disable iff (reset) (|(flags_a & ~mask_a)) |=> !alarm_out_a_n;
    endproperty
    a_alarm_on: assert property (p_alarm_on)
        else $error("alarm output not active");
    property p_alarm_off;
        @(posedge clk) disable iff (reset) (flags_a == 5'h00) |=> alarm_out_a_n;
    endproperty
    a_alarm_off: assert property (p_alarm_off)
        else $error("alarm output active with no flags");
    property p_mask_blocks;
        @(posedge clk) disable iff (reset)
            (flags_a != 5'h00 && (flags_a & ~mask_a) == 5'h00) |=> alarm_out_a_n;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("masked flag reached alarm output");

    c_alarm_fires: cover property (@(posedge clk) disable iff (reset) $fell(alarm_out_a_n));
    c_init_ends: cover property (@(posedge clk) disable iff (reset) $fell(init_pending_flag));
    c_fault_seen: cover property (@(posedge clk) disable iff (reset) ch_fault);
    c_read_done: cover property (@(posedge link_clk) disable iff (link_rst) rd_valid);
endmodule // thermal_status_flag_logic
`default_nettype wire

/* testbench/link_host.sv */
// Purpose: read-link host model for the status flag block
// Assumes: requests change only on the falling edge of link_clk
// Notes: released command lines show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module link_host (
    // link clock
    input wire logic link_clk,
    // request lines
    output logic rd_req,
    output logic [7:0] rd_cmd,
    // answer lines
    input wire logic rd_ready,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data
);
    // ---------------------------------------------------------
    // idle lines and one read
    // ---------------------------------------------------------
    initial
    begin
        rd_req = 1'b0;
        rd_cmd = 8'h00;
    end
    // hold the request until taken, then wait for the answer edge
    task automatic read(input logic [7:0] cmd, output logic [7:0] data);
        int n;
        n = 0;
        @(negedge link_clk);
        rd_req = 1'b1;
        rd_cmd = cmd;
        // bounded waits so a dead link cannot hang the model
        do
        begin
            @(posedge link_clk);
            n++;
        end
        while (rd_ready !== 1'b1 && n < 200);
        @(negedge link_clk);
        rd_req = 1'b0;
        rd_cmd = ~cmd;
        do
        begin
            @(posedge link_clk);
            n++;
        end
        while (rd_valid !== 1'b1 && n < 400);
        // a read that never answered hands back unknowns so the compare fails
        data = (rd_valid === 1'b1) ? rd_data : 8'hXX;
    endtask
endmodule // link_host
`default_nettype wire

/* testbench/thermal_status_flag_logic_test.sv */
// Purpose: self-checking bench for the thermal status flag logic
// Assumes: short power-up count, host model on the read link
// Notes: inputs move on falling edges of their own clock
`timescale 1ns/1ps
`default_nettype none
module thermal_status_flag_logic_test;
    import thermal_status_pkg::*;
    // ---------------------------------------------------------
    // signals and clocks
    // ---------------------------------------------------------
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset = 1'b1;
    logic conv_active = 1'b0;
    logic conv_done = 1'b0;
    logic [2:0] conv_chan = 3'h0;
    logic [7:0] conv_temp_u = 8'h00;
    logic [7:0] conv_temp_s = 8'h00;
    logic [3:0] diode_low_pin = 4'h0;
    logic [3:0] diode_high_pin = 4'h0;
    logic [4:0] mask_a = 5'h00;
    logic [4:0] mask_b = 5'h00;
    logic [4:0] mask_c = 5'h00;
    logic [7:0] temp_u_out, temp_s_out;
    logic alarm_out_a_n, alarm_out_b_n, alarm_out_c_n;
    logic rd_req, rd_ready, rd_valid;
    logic [7:0] rd_cmd, rd_data;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    // link clock starts off phase so the two never line up
    initial #1.3 forever #3 link_clk = ~link_clk;
    // limits fixed: a set at 0x50, remotes 1 and 2 second set at 0x60
    thermal_status_flag_logic #(.INIT_LEN(20)) dut (.clk(clk), .reset(reset),
        .conv_active(conv_active), .conv_done(conv_done), .conv_chan(conv_chan),
        .conv_temp_u(conv_temp_u), .conv_temp_s(conv_temp_s),
        .diode_low_pin(diode_low_pin), .diode_high_pin(diode_high_pin),
        .limit_a({5{8'h50}}), .limit_b12({2{8'h60}}), .hysteresis(8'h05),
        .mask_a(mask_a), .mask_b(mask_b), .mask_c(mask_c),
        .temp_u_out(temp_u_out), .temp_s_out(temp_s_out), .alarm_out_a_n(alarm_out_a_n),
        .alarm_out_b_n(alarm_out_b_n), .alarm_out_c_n(alarm_out_c_n), .link_clk(link_clk),
        .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_ready(rd_ready), .rd_valid(rd_valid),
        .rd_data(rd_data));
    link_host host (.link_clk(link_clk), .rd_req(rd_req), .rd_cmd(rd_cmd),
        .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data));
    // ---------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------
    task automatic end_sim();
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] d;
        host.read(cmd, d);
        check(d, exp);
    endtask
    // one end-of-conversion pulse, then two edges so the outputs settle
    task automatic conv(input logic [2:0] ch, input logic [7:0] t);
        @(negedge clk);
        conv_done = 1'b1;
        conv_chan = ch;
        conv_temp_u = t;
        conv_temp_s = t;
        @(negedge clk);
        conv_done = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // hang guard: generous against a run of a few hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles >= 8000)
        begin
            err_total++;
            end_sim();
        end
    end
    // ---------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------
    initial
    begin
        repeat (12) @(negedge clk);
        reset = 1'b0;
        rd(CMD_COMMON_STATUS, 8'h40);
        repeat (30) @(negedge clk);
        rd(CMD_COMMON_STATUS, 8'h00);
        @(negedge clk);
        conv_active = 1'b1;
        rd(CMD_COMMON_STATUS, 8'h80);
        @(negedge clk);
        conv_active = 1'b0;
        rd(8'h03, UNMAPPED_DATA);
        // set, hold inside the band, then clear below limit minus 5
        conv(3'h1, 8'h50);
        rd(CMD_ALARM_A, 8'h02);
        check(alarm_out_a_n, 1'b0);
        rd(CMD_COMMON_STATUS, 8'h02);
        conv(3'h1, 8'h4B);
        rd(CMD_ALARM_A, 8'h02);
        conv(3'h1, 8'h4A);
        rd(CMD_ALARM_A, 8'h00);
        check(alarm_out_a_n, 1'b1);
        // every channel over both limit sets, masks differ per output
        @(negedge clk);
        mask_a = 5'h1F;
        mask_c = 5'h1E;
        for (int ch = 0; ch < NUM_CH; ch++)
            conv(ch[2:0], 8'h7F);
        rd(CMD_ALARM_A, 8'h1F);
        rd(CMD_ALARM_B, 8'h1F);
        rd(CMD_ALARM_C, 8'h1F);
        rd(CMD_COMMON_STATUS, 8'h0E);
        check(alarm_out_a_n, 1'b1);
        check(alarm_out_b_n, 1'b0);
        check(alarm_out_c_n, 1'b0);
        // remote 1 sits above its first limit but under its second
        conv(3'h1, 8'h55);
        rd(CMD_ALARM_B, 8'h1D);
        for (int ch = 0; ch < NUM_CH; ch++)
            conv(ch[2:0], 8'h00);
        check(alarm_out_b_n, 1'b1);
        check(alarm_out_c_n, 1'b1);
        // remote 4 open, remote 1 short; pins settle before the ends
        @(negedge clk);
        diode_high_pin = 4'b1000;
        diode_low_pin = 4'b0001;
        repeat (3) @(negedge clk);
        conv(3'h1, 8'h33);
        conv(3'h4, 8'h33);
        check(temp_u_out, FAULT_TEMP_U);
        check(temp_s_out, FAULT_TEMP_S);
        rd(CMD_DIODE_FAULT, 8'h81);
        rd(CMD_COMMON_STATUS, 8'h01);
        conv(3'h0, 8'h33);
        check(temp_u_out, 8'h33);
        end_sim();
    end
endmodule // thermal_status_flag_logic_test
`default_nettype wire
